//--- vdta_pkg.sv
package vdta_pkg;

  // Register indices; byte address is four times the index
  localparam logic [12:0] IDX_VLAN_CMD  = 13'h180B;
  localparam logic [12:0] IDX_VLAN_WR   = 13'h180C;
  localparam logic [12:0] IDX_VLAN_RD   = 13'h180E;
  localparam logic [12:0] IDX_VLAN_STS  = 13'h1810;
  localparam logic [12:0] IDX_DS_CMD    = 13'h1811;
  localparam logic [12:0] IDX_DS_WR     = 13'h1812;
  localparam logic [12:0] IDX_DS_RD     = 13'h1813;
  localparam logic [12:0] IDX_DS_STS    = 13'h1814;
  localparam logic [12:0] IDX_ADMIT     = 13'h1815;
  localparam logic [12:0] IDX_EGR_TYPE  = 13'h1816;

  // Field positions
  localparam int unsigned DS_DIR_BIT    = 7;
  localparam int unsigned VL_DIR_BIT    = 5;
  localparam int unsigned VL_SEL_BIT    = 4;
  localparam int unsigned PEND_BIT      = 0;

  // Values after reset and cycle counts
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  localparam logic [1:0]  OP_CYCLES     = 2'h2;
  localparam int unsigned NUM_PORTS     = 3;
  localparam int unsigned VLAN_ENTRIES  = 16;
  localparam int unsigned DS_ENTRIES    = 64;

  // One VLAN table entry, port 2 pair on top
  typedef struct packed {
    logic        member2;
    logic        untag2;
    logic        member1;
    logic        untag1;
    logic        member0;
    logic        untag0;
    logic [11:0] vid;
  } vdta_vlan_entry_t;

  // One default VID entry
  typedef struct packed {
    logic [2:0]  prio;
    logic [11:0] vid;
  } vdta_pvid_entry_t;

  // Frame lookup request from the switch engine
  typedef struct packed {
    logic        valid;
    logic [1:0]  rx_port;
    logic [11:0] vid;
  } vdta_frame_req_t;

endpackage

//--- vdta_core.sv
`timescale 1ns/1ps
module vdta_core
  import vdta_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            reset,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [14:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Frame VLAN lookup
  input  wire vdta_frame_req_t frame_req,
  output logic                 vid_hit,
  output logic                 admit_frame,
  output logic [2:0]           member_mask,
  output logic [2:0]           strip_mask,
  // Code point to priority lookup
  input  wire logic            code_valid,
  input  wire logic [5:0]      code_point,
  output logic [2:0]           rx_priority
);

  // Pick one port's bit out of a three-bit map; port 3 reads as zero
  function automatic logic port_bit(input logic [2:0] map, input logic [1:0] p);
    port_bit = (p < 2'd3) ? map[p] : 1'b0;
  endfunction

  // Member bits of an entry as a port map
  function automatic logic [2:0] members(input vdta_vlan_entry_t e);
    members = {e.member2, e.member1, e.member0};
  endfunction

  // Untag bits of an entry as a port map
  function automatic logic [2:0] untags(input vdta_vlan_entry_t e);
    untags = {e.untag2, e.untag1, e.untag0};
  endfunction

  logic [31:0]      prdata_reg, prdata_next;
  logic             pready_reg, pready_next;
  logic             pslverr_reg, pslverr_next;
  logic [5:0]       vl_cmd_reg, vl_cmd_next;
  vdta_vlan_entry_t vl_wr_reg, vl_wr_next;
  logic [17:0]      vl_rd_reg, vl_rd_next;
  logic [1:0]       vl_cnt_reg, vl_cnt_next;
  logic [7:0]       ds_cmd_reg, ds_cmd_next;
  logic [2:0]       ds_wr_reg, ds_wr_next;
  logic [2:0]       ds_rd_reg, ds_rd_next;
  logic [1:0]       ds_cnt_reg, ds_cnt_next;
  logic [2:0]       admit_nonmember_reg, admit_nonmember_next;
  logic [2:0]       egress_port_type_reg, egress_port_type_next;
  logic [12:0]      apb_idx;
  logic             take_wr;
  logic             vl_pend, ds_pend, vl_done, ds_done;
  logic [3:0]       vl_idx;
  logic [5:0]       ds_idx;

  // Tables; the code point table is deliberately left unreset
  vdta_vlan_entry_t vlan_mem [VLAN_ENTRIES];
  vdta_pvid_entry_t pvid_mem [NUM_PORTS];
  logic [2:0]       ds_mem   [DS_ENTRIES];

  // Access decode; a write counts only at the edge where pready is seen high
  assign apb_idx = paddr[14:2];
  assign take_wr = psel & penable & pready_reg & pwrite;
  assign vl_pend = (vl_cnt_reg != 2'h0);
  assign ds_pend = (ds_cnt_reg != 2'h0);
  assign vl_done = (vl_cnt_reg == 2'h1);
  assign ds_done = (ds_cnt_reg == 2'h1);
  assign vl_idx  = vl_cmd_reg[3:0];
  assign ds_idx  = ds_cmd_reg[5:0];

  // Bus answer: one wait state, unaligned or unmapped gives an error
  always_comb
  begin
    pready_next  = psel & penable & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next  = prdata_reg;
    if (pready_next)
    begin
      prdata_next = 32'h0000_0000;
      case (apb_idx)
        IDX_VLAN_CMD: prdata_next = {26'h0, vl_cmd_reg};
        IDX_VLAN_WR:  prdata_next = {14'h0, vl_wr_reg};
        IDX_VLAN_RD:  prdata_next = {14'h0, vl_rd_reg};
        IDX_VLAN_STS: prdata_next = {31'h0, vl_pend};
        IDX_DS_CMD:   prdata_next = {24'h0, ds_cmd_reg};
        IDX_DS_WR:    prdata_next = {29'h0, ds_wr_reg};
        IDX_DS_RD:    prdata_next = {29'h0, ds_rd_reg};
        IDX_DS_STS:   prdata_next = {31'h0, ds_pend};
        IDX_ADMIT:    prdata_next = {29'h0, admit_nonmember_reg};
        IDX_EGR_TYPE: prdata_next = {29'h0, egress_port_type_reg};
        default:      pslverr_next = 1'b1;
      endcase
      if (paddr[1:0] != 2'b00)
        pslverr_next = 1'b1;
    end
  end

  // Software writes and command sequencing
  always_comb
  begin
    vl_cmd_next           = vl_cmd_reg;
    vl_wr_next            = vl_wr_reg;
    ds_cmd_next           = ds_cmd_reg;
    ds_wr_next            = ds_wr_reg;
    admit_nonmember_next  = admit_nonmember_reg;
    egress_port_type_next = egress_port_type_reg;
    vl_cnt_next           = vl_pend ? vl_cnt_reg - 2'h1 : 2'h0;
    ds_cnt_next           = ds_pend ? ds_cnt_reg - 2'h1 : 2'h0;
    if (take_wr && paddr[1:0] == 2'b00)
    begin
      case (apb_idx)
        IDX_VLAN_CMD:
        begin
          vl_cmd_next = pwdata[5:0];
          vl_cnt_next = OP_CYCLES;
        end
        IDX_VLAN_WR:  vl_wr_next = pwdata[17:0];
        IDX_DS_CMD:
        begin
          ds_cmd_next = {pwdata[DS_DIR_BIT], 1'b0, pwdata[5:0]};
          ds_cnt_next = OP_CYCLES;
        end
        IDX_DS_WR:    ds_wr_next = pwdata[2:0];
        IDX_ADMIT:    admit_nonmember_next = pwdata[2:0];
        IDX_EGR_TYPE: egress_port_type_next = pwdata[2:0];
        default:      vl_cmd_next = vl_cmd_reg;
      endcase
    end
  end

  // Read results land on the last pending cycle
  always_comb
  begin
    vl_rd_next = vl_rd_reg;
    ds_rd_next = ds_rd_reg;
    if (vl_done && vl_cmd_reg[VL_DIR_BIT])
    begin
      if (vl_cmd_reg[VL_SEL_BIT])
        vl_rd_next = (vl_idx < 4'd3) ? {3'h0, pvid_mem[vl_idx[1:0]]} : 18'h0;
      else
        vl_rd_next = vlan_mem[vl_idx];
    end
    if (ds_done && ds_cmd_reg[DS_DIR_BIT])
      ds_rd_next = ds_mem[ds_idx];
  end

  // Control and status registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      prdata_reg           <= REG_RESET;
      pready_reg           <= 1'b0;
      pslverr_reg          <= 1'b0;
      vl_cmd_reg           <= REG_RESET[5:0];
      vl_wr_reg            <= REG_RESET[17:0];
      vl_rd_reg            <= REG_RESET[17:0];
      vl_cnt_reg           <= REG_RESET[1:0];
      ds_cmd_reg           <= REG_RESET[7:0];
      ds_wr_reg            <= REG_RESET[2:0];
      ds_rd_reg            <= REG_RESET[2:0];
      ds_cnt_reg           <= REG_RESET[1:0];
      admit_nonmember_reg  <= REG_RESET[2:0];
      egress_port_type_reg <= REG_RESET[2:0];
    end
    else
    begin
      prdata_reg           <= prdata_next;
      pready_reg           <= pready_next;
      pslverr_reg          <= pslverr_next;
      vl_cmd_reg           <= vl_cmd_next;
      vl_wr_reg            <= vl_wr_next;
      vl_rd_reg            <= vl_rd_next;
      vl_cnt_reg           <= vl_cnt_next;
      ds_cmd_reg           <= ds_cmd_next;
      ds_wr_reg            <= ds_wr_next;
      ds_rd_reg            <= ds_rd_next;
      ds_cnt_reg           <= ds_cnt_next;
      admit_nonmember_reg  <= admit_nonmember_next;
      egress_port_type_reg <= egress_port_type_next;
    end
  end

  // VLAN and default VID tables clear at reset, entries default to zero
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < VLAN_ENTRIES; i++)
        vlan_mem[i] <= '0;
      for (int i = 0; i < NUM_PORTS; i++)
        pvid_mem[i] <= '0;
    end
    else if (vl_done && !vl_cmd_reg[VL_DIR_BIT])
    begin
      if (!vl_cmd_reg[VL_SEL_BIT])
        vlan_mem[vl_idx] <= vl_wr_reg;
      else if (vl_idx < 4'd3)
        pvid_mem[vl_idx[1:0]] <= vl_wr_reg[14:0];
    end
  end

  // Code point table has no reset, software must fill it
  always_ff @(posedge mclk)
  begin
    if (ds_done && !ds_cmd_reg[DS_DIR_BIT])
      ds_mem[ds_idx] <= ds_wr_reg;
  end

  // VID search, lowest matching entry wins
  logic             lk_hit;
  vdta_vlan_entry_t lk_ent;
  logic [2:0]       exp_prio;
  always_comb
  begin
    lk_hit = 1'b0;
    lk_ent = '0;
    for (int i = VLAN_ENTRIES - 1; i >= 0; i--)
    begin
      if (vlan_mem[i].vid == frame_req.vid)
      begin
        lk_hit = 1'b1;
        lk_ent = vlan_mem[i];
      end
    end
  end
  assign exp_prio = ds_mem[code_point];

  // Frame verdicts, registered so every output leaves a flop
  logic       hit_reg, hit_next;
  logic       admit_reg, admit_next;
  logic [2:0] mem_reg, mem_next;
  logic [2:0] strip_reg, strip_next;
  logic [2:0] prio_reg, prio_next;
  always_comb
  begin
    hit_next   = hit_reg;
    admit_next = admit_reg;
    mem_next   = mem_reg;
    strip_next = strip_reg;
    prio_next  = code_valid ? exp_prio : prio_reg;
    if (frame_req.valid)
    begin
      hit_next   = lk_hit;
      mem_next   = lk_hit ? members(lk_ent) : 3'h0;
      admit_next = port_bit(mem_next, frame_req.rx_port)
                 | port_bit(admit_nonmember_reg, frame_req.rx_port);
      // Only hybrid ports strip, and only when the ingress port untags
      strip_next = port_bit(untags(lk_ent), frame_req.rx_port) && lk_hit
                 ? (egress_port_type_reg & mem_next) : 3'h0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hit_reg   <= 1'b0;
      admit_reg <= 1'b0;
      mem_reg   <= 3'h0;
      strip_reg <= 3'h0;
      prio_reg  <= 3'h0;
    end
    else
    begin
      hit_reg   <= hit_next;
      admit_reg <= admit_next;
      mem_reg   <= mem_next;
      strip_reg <= strip_next;
      prio_reg  <= prio_next;
    end
  end

  // Outputs straight from flops
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign vid_hit     = hit_reg;
  assign admit_frame = admit_reg;
  assign member_mask = mem_reg;
  assign strip_mask  = strip_reg;
  assign rx_priority = prio_reg;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_ds_cmd;
    take_wr && apb_idx == IDX_DS_CMD && paddr[1:0] == 2'b00;
  endsequence
  sequence s_vl_cmd;
    take_wr && apb_idx == IDX_VLAN_CMD && paddr[1:0] == 2'b00;
  endsequence
  sequence s_pend_run(logic p);
    p [*2] ##1 !p;
  endsequence

  chk_ds_launch: assert property (s_ds_cmd |=> ds_pend)
    else $error("code point command did not start");
  chk_ds_pend_len: assert property (s_ds_cmd |=> s_pend_run(ds_pend))
    else $error("code point pending length wrong");
  chk_vl_pend_len: assert property (s_vl_cmd |=> s_pend_run(vl_pend))
    else $error("vlan pending length wrong");
  chk_ds_store: assert property ($fell(ds_pend) && !ds_cmd_reg[DS_DIR_BIT]
                                 |-> ds_mem[ds_idx] == ds_wr_reg)
    else $error("table write lost");
  chk_ds_fetch: assert property ($fell(ds_pend) && ds_cmd_reg[DS_DIR_BIT]
                                 |-> ds_rd_reg == ds_mem[ds_idx])
    else $error("table read wrong");
  chk_ds_dir_reset: assert property ($rose(ds_pend) && !$past(pwdata[DS_DIR_BIT])
                                     |-> !ds_cmd_reg[DS_DIR_BIT])
    else $error("direction bit wrong");
  chk_prio_lookup: assert property (code_valid |=> prio_reg == $past(exp_prio))
    else $error("priority lookup wrong");
  chk_vl_vid: assert property ($fell(vl_pend) && vl_cmd_reg[VL_DIR_BIT]
                               && !vl_cmd_reg[VL_SEL_BIT]
                               |-> vl_rd_reg[11:0] == vlan_mem[vl_idx].vid)
    else $error("vid readback wrong");
  chk_strip_hybrid: assert property (frame_req.valid
                                     |=> (strip_reg & ~$past(egress_port_type_reg)) == 3'h0)
    else $error("tag stripped on non hybrid port");
  chk_admit_nonmem: assert property (frame_req.valid
                                     && port_bit(admit_nonmember_reg, frame_req.rx_port)
                                     |=> admit_reg)
    else $error("admitted non member filtered");

endmodule // vdta_core

//--- vlan_dscp_table_access_test.sv
`timescale 1ns/1ps
module vlan_dscp_table_access_test
  import vdta_pkg::*;
;
  // Clock, reset and register bus
  logic            mclk;
  logic            reset;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [14:0]     paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  // Lookup ports
  vdta_frame_req_t frame_req;
  logic            vid_hit;
  logic            admit_frame;
  logic [2:0]      member_mask;
  logic [2:0]      strip_mask;
  logic            code_valid;
  logic [5:0]      code_point;
  logic [2:0]      rx_priority;
  // Bench state
  int              seed;
  int              failures;
  int              n_compared;
  int              k;
  logic [31:0]     rdv;
  logic [31:0]     tmp;
  logic [31:0]     ent;
  logic            errv;
  logic [2:0]      last_p;
  logic [2:0]      hyb;
  logic [2:0]      adm;
  logic [2:0]      ds_m [64];
  logic [12:0]     rst_list [5];

  vdta_core dut_u (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_req(frame_req), .vid_hit(vid_hit), .admit_frame(admit_frame),
    .member_mask(member_mask), .strip_mask(strip_mask), .code_valid(code_valid),
    .code_point(code_point), .rx_priority(rx_priority)
  );

  // Free running clock, 40 ns period
  always #20 mclk = ~mclk;

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; request held until pready is sampled high, bounded wait
  task automatic apb(input logic wr, input logic [12:0] idx, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      failures++;
      finish_test();
    end
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // Poll a status register until its pending flag drops
  task automatic wait_idle(input logic [12:0] idx);
    int n;
    n = 0;
    do
    begin
      apb(1'h0, idx, 32'h0);
      n++;
    end
    while (rdv[PEND_BIT] !== 1'h0 && n < 10);
    if (rdv[PEND_BIT] !== 1'h0)
    begin
      failures++;
      finish_test();
    end
  endtask

  task automatic ds_write(input logic [5:0] i, input logic [2:0] p);
    apb(1'h1, IDX_DS_WR, {29'h0, p});
    apb(1'h1, IDX_DS_CMD, {24'h0, 2'h0, i});
    wait_idle(IDX_DS_STS);
    check(rdv, 32'h0);
    ds_m[i] = p;
    last_p = p;
  endtask

  // Expected {hit, admit, members, strip} for a hit on entry e
  function automatic logic [31:0] frame_exp(input logic [17:0] e, input logic [1:0] p,
                                            input logic [2:0] h, input logic [2:0] a);
    logic [2:0] mem;
    logic [2:0] unt;
    mem = {e[17], e[15], e[13]};
    unt = {e[16], e[14], e[12]};
    frame_exp = {24'h0, 1'h1, mem[p] | a[p], mem, unt[p] ? (h & mem) : 3'h0};
  endfunction

  task automatic frame(input logic [1:0] p, input logic [11:0] v);
    @(posedge mclk);
    frame_req <= '{valid: 1'h1, rx_port: p, vid: v};
    @(posedge mclk);
    frame_req.valid <= 1'h0;
    @(negedge mclk);
  endtask

  // One code point lookup; result is looked at mid-cycle after the answer edge
  task automatic lookup_prio(input logic [5:0] c);
    @(posedge mclk);
    code_valid <= 1'h1;
    code_point <= c;
    @(posedge mclk);
    code_valid <= 1'h0;
    @(negedge mclk);
  endtask

  // Hang guard well above the expected run length
  initial
  begin
    #1000000;
    failures++;
    finish_test();
  end

  initial
  begin
    mclk = 1'h0;
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 15'h0;
    pwdata = 32'h0;
    frame_req = '0;
    code_valid = 1'h0;
    code_point = 6'h0;
    seed = 54;
    failures = 0;
    n_compared = 0;
    rst_list = '{IDX_VLAN_STS, IDX_DS_CMD, IDX_DS_WR, IDX_DS_RD, IDX_DS_STS};
    repeat (12) @(posedge mclk);
    reset <= 1'h0;
    // Register values after reset
    for (k = 0; k < 5; k++)
    begin
      apb(1'h0, rst_list[k], 32'h0);
      check(rdv, REG_RESET);
      check({31'h0, errv}, 32'h0);
    end
    // Unmapped index is refused
    apb(1'h0, 13'h0001, 32'h0);
    check({31'h0, errv}, 32'h1);
    // Fill the whole table, since reset leaves it undefined
    for (k = 0; k < 64; k++)
    begin
      tmp = $random(seed);
      ds_write(k[5:0], tmp[2:0]);
    end
    // Command register keeps only direction and index; reserved bit 6 reads 0
    tmp = $random(seed);
    apb(1'h1, IDX_DS_CMD, tmp);
    if (tmp[DS_DIR_BIT] == 1'h0)
      ds_m[tmp[5:0]] = last_p;
    wait_idle(IDX_DS_STS);
    apb(1'h0, IDX_DS_CMD, 32'h0);
    check(rdv, tmp & 32'hBF);
    // Read back entries through read commands, corners first
    for (k = 0; k < 40; k++)
    begin
      tmp = (k == 0) ? 32'h0 : (k == 1) ? 32'h3F : $random(seed);
      apb(1'h1, IDX_DS_CMD, {24'h0, 2'h2, tmp[5:0]});
      wait_idle(IDX_DS_STS);
      apb(1'h0, IDX_DS_RD, 32'h0);
      check(rdv, {29'h0, ds_m[tmp[5:0]]});
    end
    // Code point lookup
    for (k = 0; k < 16; k++)
    begin
      tmp = (k == 0) ? 32'h0 : (k == 1) ? 32'h3F : $random(seed);
      lookup_prio(tmp[5:0]);
      check({29'h0, rx_priority}, {29'h0, ds_m[tmp[5:0]]});
    end
    // Default VID table entry through the table select
    ent = $random(seed);
    apb(1'h1, IDX_VLAN_WR, ent);
    apb(1'h1, IDX_VLAN_CMD, 32'h11);
    wait_idle(IDX_VLAN_STS);
    check(rdv, 32'h0);
    apb(1'h1, IDX_VLAN_CMD, 32'h31);
    wait_idle(IDX_VLAN_STS);
    apb(1'h0, IDX_VLAN_RD, 32'h0);
    check(rdv, ent & 32'h7FFF);
    // VLAN entries, membership and tag stripping per receive port
    for (k = 0; k < 9; k++)
    begin
      ent = $random(seed) | 32'h1;
      tmp = $random(seed);
      hyb = tmp[2:0];
      adm = tmp[5:3];
      apb(1'h1, IDX_ADMIT, {29'h0, adm});
      apb(1'h1, IDX_EGR_TYPE, {29'h0, hyb});
      apb(1'h1, IDX_VLAN_WR, {14'h0, ent[17:0]});
      apb(1'h1, IDX_VLAN_CMD, 32'h05);
      wait_idle(IDX_VLAN_STS);
      check(rdv, 32'h0);
      apb(1'h1, IDX_VLAN_CMD, 32'h25);
      wait_idle(IDX_VLAN_STS);
      apb(1'h0, IDX_VLAN_RD, 32'h0);
      check(rdv, {14'h0, ent[17:0]});
      tmp = k % 3;
      frame(tmp[1:0], ent[11:0]);
      check({24'h0, vid_hit, admit_frame, member_mask, strip_mask},
            frame_exp(ent[17:0], tmp[1:0], hyb, adm));
      frame(tmp[1:0], ent[11:0] ^ 12'h800);
      check({24'h0, vid_hit, admit_frame, member_mask, strip_mask},
            {24'h0, 1'h0, adm[tmp[1:0]], 6'h0});
    end
    // Mid-run reset clears verdicts and command fields but keeps the code point table
    @(posedge mclk);
    reset <= 1'h1;
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    @(negedge mclk);
    check({24'h0, vid_hit, admit_frame, member_mask, strip_mask}, 32'h0);
    apb(1'h0, IDX_DS_CMD, 32'h0);
    check(rdv, REG_RESET);
    for (k = 0; k < 4; k++)
    begin
      tmp = $random(seed);
      lookup_prio(tmp[5:0]);
      check({29'h0, rx_priority}, {29'h0, ds_m[tmp[5:0]]});
    end
    finish_test();
  end
endmodule // vlan_dscp_table_access_test
